// file: hdl/clock_gen_pkg.sv
// Package with register map, field layout, reset values and timing counts of the clock block.
package clock_gen_pkg;
    // Register indices on the plain register port.
    localparam logic [3:0] PRIMARY_MODE_CONFIG_ADDR = 4'h0;
    localparam logic [3:0] LINE_XCVR_CONFIG_ONE_ADDR = 4'h1;
    localparam logic [3:0] BLOCK_RESET_REGISTER_ADDR = 4'h2;
    localparam logic [3:0] CLOCK_STATUS_ADDR = 4'h3;

    // Field positions inside primary_mode_config.
    localparam int MCU_SEL_LSB = 0;
    localparam int CLOCK_DOUBLE_SELECT_BIT = 2;
    localparam int RESET_SOURCE_SELECT_LSB = 3;
    // Field position inside line_xcvr_config_one.
    localparam int PLL_INTEGRATOR_DISABLE_BIT = 0;

    // Reset values.
    localparam logic [7:0] PRIMARY_MODE_CONFIG_RST = 8'h00;
    localparam logic [7:0] LINE_XCVR_CONFIG_ONE_RST = 8'h00;
    localparam logic [7:0] BLOCK_RESET_REGISTER_RST = 8'h00;

    // Controller clock divider selections.
    localparam logic [1:0] MCU_DIV1 = 2'h0;
    localparam logic [1:0] MCU_DIV2 = 2'h1;
    localparam logic [1:0] MCU_DIV8 = 2'h2;
    localparam logic [1:0] MCU_OFF = 2'h3;

    // Reset output function selections.
    localparam logic [1:0] RSS_NONE = 2'h0;
    localparam logic [1:0] RSS_STROBE = 2'h1;
    localparam logic [1:0] RSS_WAKE = 2'h2;
    localparam logic [1:0] RSS_WATCHDOG = 2'h3;

    // Clock rates; the oscillator strobe marks quarter periods of the master clock.
    localparam int MASTER_CLOCK_KHZ = 15360;
    localparam int DATA_CLOCK_KHZ = 1536;
    localparam int FRAME_SYNC_KHZ = 8;
    localparam int QUARTERS_PER_MASTER = 4;
    localparam int DCL_QUARTERS = QUARTERS_PER_MASTER * MASTER_CLOCK_KHZ / DATA_CLOCK_KHZ;
    localparam int DCL_PER_FRAME = DATA_CLOCK_KHZ / FRAME_SYNC_KHZ;
    localparam int DEV_LIMIT_DEFAULT = 6;

    // Internal reset pulse: between 125 us and 250 us, timed by frame sync edges.
    localparam int RST_PULSE_MIN_US = 125;
    localparam int RST_PULSE_MAX_US = 250;
    localparam int FRAME_PERIOD_US = 1000 / FRAME_SYNC_KHZ;
    localparam logic [1:0] RST_PULSE_FRAMES = 2'(RST_PULSE_MAX_US / FRAME_PERIOD_US);
endpackage

// file: hdl/clock_gen_and_reset_dist.sv
// Clock generation from the oscillator, line-locked highway clocks and reset distribution.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module clock_gen_and_reset_dist #(
    parameter int DEV_LIMIT = clock_gen_pkg::DEV_LIMIT_DEFAULT,
    parameter int NUM_BLOCKS = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic osc_quarter_i,
    input wire logic line_pulse_i,
    input wire logic ci_change_i,
    input wire logic subscriber_wake_in_n_i,
    input wire logic watchdog_expire_i,
    input wire logic data_strobe_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic frame_sync_o,
    output logic highway_data_clock_o,
    output logic highway_bit_clock_o,
    output logic line_tx_tick_o,
    output logic mcu_clk_o,
    output logic mcu_clk_oe_o,
    output logic reset_out_or_strobe_n_o,
    output logic [NUM_BLOCKS-1:0] block_rst_o
);
    localparam int DCLQ = clock_gen_pkg::DCL_QUARTERS;
    localparam int FPOS = clock_gen_pkg::DCL_PER_FRAME;
    localparam int QM = clock_gen_pkg::QUARTERS_PER_MASTER;

    generate
        if (DEV_LIMIT < 1 || DEV_LIMIT > 15 || NUM_BLOCKS < 1 || NUM_BLOCKS > 8) begin : g_bad
            $error("clock_gen_and_reset_dist: unsupported parameter values");
        end
    endgenerate

    typedef enum {PD_NONE, PD_LONG, PD_SHORT} corr_t;

    logic [7:0] mode_reg;
    logic [7:0] xcvr_reg;
    logic [7:0] bres_reg;
    logic [5:0] qcnt_reg;
    logic [7:0] fpos_reg;
    logic [7:0] fpos_next;
    corr_t corr_reg;
    logic [3:0] dev_cnt_reg;
    logic dev_dir_reg;
    logic [4:0] mcu_cnt_reg;
    logic rst_hold_reg;
    logic [1:0] pulse_cnt_reg;
    logic wake_d_reg;
    logic [5:0] period_len;
    logic period_end;
    logic bclk_fall;
    logic dev_evt;
    logic dev_dir;
    logic [3:0] dev_cnt_new;
    logic corr_set;
    logic rst_evt;
    logic [1:0] rss;
    logic intd;

    assign rss = mode_reg[clock_gen_pkg::RESET_SOURCE_SELECT_LSB +: 2];
    assign intd = xcvr_reg[clock_gen_pkg::PLL_INTEGRATOR_DISABLE_BIT];

    // Half period of the controller clock, in oscillator quarter strobes.
    function automatic logic [4:0] mcu_half(input logic [1:0] sel, input logic dbl);
        logic [4:0] h;
        h = 5'h02;
        unique case (sel)
            clock_gen_pkg::MCU_DIV1: h = 5'h02;
            clock_gen_pkg::MCU_DIV2: h = 5'h04;
            clock_gen_pkg::MCU_DIV8: h = 5'h10;
            clock_gen_pkg::MCU_OFF: h = 5'h02;
        endcase
        return dbl ? (h >> 1) : h;
    endfunction

    // Register port. The source select is frozen once the watchdog is chosen.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_reg <= clock_gen_pkg::PRIMARY_MODE_CONFIG_RST;
            xcvr_reg <= clock_gen_pkg::LINE_XCVR_CONFIG_ONE_RST;
            bres_reg <= clock_gen_pkg::BLOCK_RESET_REGISTER_RST;
        end else if (ce_i && reg_wr_i) begin
            unique case (reg_addr_i)
                clock_gen_pkg::PRIMARY_MODE_CONFIG_ADDR: begin
                    mode_reg[2:0] <= reg_wdata_i[2:0];
                    if (rss != clock_gen_pkg::RSS_WATCHDOG) begin
                        mode_reg[4:3] <= reg_wdata_i[4:3];
                    end
                end
                clock_gen_pkg::LINE_XCVR_CONFIG_ONE_ADDR: xcvr_reg <= {7'h00, reg_wdata_i[0]};
                clock_gen_pkg::BLOCK_RESET_REGISTER_ADDR: bres_reg <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            reg_rdata_o <= 8'h00;
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    clock_gen_pkg::PRIMARY_MODE_CONFIG_ADDR: reg_rdata_o <= {3'h0, mode_reg[4:0]};
                    clock_gen_pkg::LINE_XCVR_CONFIG_ONE_ADDR: reg_rdata_o <= xcvr_reg;
                    clock_gen_pkg::BLOCK_RESET_REGISTER_ADDR: reg_rdata_o <= bres_reg;
                    clock_gen_pkg::CLOCK_STATUS_ADDR: reg_rdata_o <= {dev_cnt_reg,
                        pulse_cnt_reg != 2'h0, rst_hold_reg, corr_reg == PD_SHORT,
                        corr_reg == PD_LONG};
                    default: reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // one master period; a too late shortening would overrun, so it waits a period
    always_comb begin
        unique case (corr_reg)
            PD_NONE: period_len = 6'(DCLQ);
            PD_LONG: period_len = 6'(DCLQ + QM);
            PD_SHORT: period_len = (qcnt_reg >= 6'(DCLQ - QM)) ? 6'(DCLQ) : 6'(DCLQ - QM);
        endcase
    end

    // all timing advances on oscillator strobes only
    assign period_end = ce_i && osc_quarter_i && (qcnt_reg == period_len - 6'h01);
    assign fpos_next = (fpos_reg == 8'(FPOS - 1)) ? 8'h00 : fpos_reg + 8'h01;
    assign bclk_fall = period_end && highway_bit_clock_o && fpos_next[0];

    // one chain: data clock period counter, then frame position
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            qcnt_reg <= 6'h00;
            fpos_reg <= 8'h00;
        end else if (ce_i && osc_quarter_i) begin
            qcnt_reg <= period_end ? 6'h00 : qcnt_reg + 6'h01;
            if (period_end) begin
                fpos_reg <= fpos_next;
            end
        end
    end

    // highway clocks from the chain position
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            highway_data_clock_o <= 1'b1;
            highway_bit_clock_o <= 1'b1;
            frame_sync_o <= 1'b1;
            line_tx_tick_o <= 1'b0;
        end else if (ce_i) begin
            line_tx_tick_o <= 1'b0;
            if (period_end) begin
                highway_data_clock_o <= 1'b1;
                highway_bit_clock_o <= ~fpos_next[0];
                frame_sync_o <= fpos_next < 8'h02;
                // transmit tick from the recovered clock
                line_tx_tick_o <= 1'b1;
            end else if (osc_quarter_i && qcnt_reg == 6'(DCLQ / 2 - 1)) begin
                highway_data_clock_o <= 1'b0;
            end
        end
    end

    // Phase detector: a pulse in the first half of the frame means local is ahead.
    assign dev_evt = ce_i && line_pulse_i && fpos_reg != 8'h00;
    assign dev_dir = fpos_reg < 8'(FPOS / 2);
    assign dev_cnt_new = (dev_cnt_reg != 4'h0 && dev_dir == dev_dir_reg) ?
        dev_cnt_reg + 4'h1 : 4'h1;
    assign corr_set = dev_evt && (intd || dev_cnt_new == 4'(DEV_LIMIT));

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            dev_cnt_reg <= 4'h0;
            dev_dir_reg <= 1'b0;
        end else if (ce_i && line_pulse_i) begin
            dev_dir_reg <= dev_dir;
            dev_cnt_reg <= (!dev_evt || corr_set) ? 4'h0 : dev_cnt_new;
        end
    end

    // pending correction; a new request wins over the clear at period end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            corr_reg <= PD_NONE;
        end else if (ce_i) begin
            if (period_end && (corr_reg != PD_SHORT || qcnt_reg != 6'(DCLQ - 1))) begin
                corr_reg <= PD_NONE;
            end
            if (corr_set) begin
                corr_reg <= dev_dir ? PD_LONG : PD_SHORT;
            end
        end
    end

    // controller clock runs from the oscillator alone, no correction
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mcu_cnt_reg <= 5'h00;
            mcu_clk_o <= 1'b0;
            mcu_clk_oe_o <= 1'b1;
        end else if (ce_i) begin
            // field 11 stops the controller clock
            mcu_clk_oe_o <= mode_reg[1:0] != clock_gen_pkg::MCU_OFF;
            if (mode_reg[1:0] == clock_gen_pkg::MCU_OFF) begin
                mcu_clk_o <= 1'b0;
                mcu_cnt_reg <= 5'h00;
            end else if (osc_quarter_i) begin
                if (mcu_cnt_reg >= mcu_half(mode_reg[1:0],
                        mode_reg[clock_gen_pkg::CLOCK_DOUBLE_SELECT_BIT]) - 5'h01) begin
                    mcu_cnt_reg <= 5'h00;
                    mcu_clk_o <= ~mcu_clk_o;
                end else begin
                    mcu_cnt_reg <= mcu_cnt_reg + 5'h01;
                end
            end
        end
    end

    assign rst_evt = ce_i && (((rss == clock_gen_pkg::RSS_WAKE) &&
        (ci_change_i || (wake_d_reg && !subscriber_wake_in_n_i))) ||
        ((rss == clock_gen_pkg::RSS_WATCHDOG) && watchdog_expire_i));

    // pulse ends at the second frame sync start, 125 to 250 us later
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pulse_cnt_reg <= 2'h0;
            wake_d_reg <= 1'b1;
        end else if (ce_i) begin
            wake_d_reg <= subscriber_wake_in_n_i;
            if (period_end && fpos_next == 8'h00 && pulse_cnt_reg != 2'h0) begin
                pulse_cnt_reg <= pulse_cnt_reg - 2'h1;
            end
            if (rst_evt) begin
                pulse_cnt_reg <= clock_gen_pkg::RST_PULSE_FRAMES;
            end
        end
    end

    // hold the hardware reset until a falling bit clock edge
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rst_hold_reg <= 1'b1;
        end else if (bclk_fall) begin
            rst_hold_reg <= 1'b0;
        end
    end

    // reset output; hardware reset overrides every selection
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            reset_out_or_strobe_n_o <= 1'b0;
        end else if (ce_i) begin
            if (rst_hold_reg) begin
                reset_out_or_strobe_n_o <= 1'b0;
            end else if (rss == clock_gen_pkg::RSS_STROBE) begin
                reset_out_or_strobe_n_o <= data_strobe_i;
            end else begin
                reset_out_or_strobe_n_o <= pulse_cnt_reg == 2'h0;
            end
        end
    end

    // block resets follow the hardware reset and their bits
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            block_rst_o <= '1;
        end else if (ce_i) begin
            block_rst_o <= bres_reg[NUM_BLOCKS-1:0];
        end
    end

    sequence s_wake_evt;
        ce_i && rst_evt && !rst_hold_reg && rss == clock_gen_pkg::RSS_WAKE;
    endsequence

    sequence s_two_ce;
        ce_i ##1 ce_i;
    endsequence

    property p_hw_rst_out;
        @(posedge clk_sys_i) disable iff (rst_i)
        rst_hold_reg && ce_i |=> !reset_out_or_strobe_n_o;
    endproperty
    a_hw_rst_out: assert property (p_hw_rst_out) else $error("reset output not low in hold");

    property p_rst_release;
        @(posedge clk_sys_i) disable iff (rst_i)
        rst_hold_reg && bclk_fall |=> !rst_hold_reg && !highway_bit_clock_o;
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("hold not released on fall");

    property p_period_len;
        @(posedge clk_sys_i) disable iff (rst_i)
        period_end |-> (qcnt_reg == 6'(DCLQ - 1) || qcnt_reg == 6'(DCLQ + QM - 1) ||
            qcnt_reg == 6'(DCLQ - QM - 1));
    endproperty
    a_period_len: assert property (p_period_len) else $error("bad data clock period");

    property p_mcu_off;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && mode_reg[1:0] == clock_gen_pkg::MCU_OFF |=> !mcu_clk_oe_o && !mcu_clk_o;
    endproperty
    a_mcu_off: assert property (p_mcu_off) else $error("controller clock still driven");

    property p_intd;
        @(posedge clk_sys_i) disable iff (rst_i)
        dev_evt && intd |=> corr_reg != PD_NONE;
    endproperty
    a_intd: assert property (p_intd) else $error("no correction after deviation");

    property p_integ;
        @(posedge clk_sys_i) disable iff (rst_i)
        corr_set && !intd |-> dev_cnt_reg == 4'(DEV_LIMIT - 1) && dev_dir == dev_dir_reg;
    endproperty
    a_integ: assert property (p_integ) else $error("correction before deviation count");

    property p_frame;
        @(posedge clk_sys_i) disable iff (rst_i)
        period_end && fpos_reg == 8'(FPOS - 1) |=> frame_sync_o && fpos_reg == 8'h00;
    endproperty
    a_frame: assert property (p_frame) else $error("frame sync misplaced");

    property p_block_rst;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && bres_reg[0] |=> block_rst_o[0] ##1 (block_rst_o[0] || !bres_reg[0] || !ce_i);
    endproperty
    a_block_rst: assert property (p_block_rst) else $error("block left reset early");

    property p_wake_pulse;
        @(posedge clk_sys_i) disable iff (rst_i)
        s_wake_evt ##1 s_two_ce |-> !reset_out_or_strobe_n_o;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake reset missing");

    property p_watchdog;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && rst_evt && !rst_hold_reg && rss == clock_gen_pkg::RSS_WATCHDOG
        |=> pulse_cnt_reg == clock_gen_pkg::RST_PULSE_FRAMES;
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog reset not started");
endmodule

// file: dv/line_side_model.sv
// Far-side model: oscillator quarter strobe and received line frame markers.
`timescale 1ns/10ps
module line_side_model #(
    parameter int QGAP = 1
) (
    input wire logic clk_sys_i,
    input wire logic frame_sync_i,
    output logic osc_quarter_o,
    output logic line_pulse_o
);
    int qcnt = 0;
    initial begin
        osc_quarter_o = 1'b0;
        line_pulse_o = 1'b0;
    end
    always @(posedge clk_sys_i) begin
        qcnt <= (qcnt + 1) % QGAP;
        osc_quarter_o <= (qcnt == 0);
    end
    // one-cycle frame marker.
    // The offset is taken from the local frame start, so every marker lands at a known position.
    task automatic send_marker(input int delay);
        @(posedge frame_sync_i);
        repeat (delay) @(posedge clk_sys_i);
        line_pulse_o <= 1'b1;
        @(posedge clk_sys_i);
        line_pulse_o <= 1'b0;
    endtask
endmodule

// file: dv/clock_gen_and_reset_dist_tb_top.sv
// Self-checking bench for clock generation and reset distribution.
`timescale 1ns/10ps
module clock_gen_and_reset_dist_tb_top;
    localparam int QGAP = 1;
    localparam int DEVN = 2;
    localparam int MQ = clock_gen_pkg::QUARTERS_PER_MASTER * QGAP;
    localparam int DQ = clock_gen_pkg::DCL_QUARTERS * QGAP;
    localparam int FRAME = clock_gen_pkg::DCL_PER_FRAME * DQ;
    localparam int TIME_LIMIT = 95000;
    localparam logic [3:0] MODE = clock_gen_pkg::PRIMARY_MODE_CONFIG_ADDR;
    localparam logic [3:0] XCFG = clock_gen_pkg::LINE_XCVR_CONFIG_ONE_ADDR;
    localparam logic [3:0] BRST = clock_gen_pkg::BLOCK_RESET_REGISTER_ADDR;
    typedef struct {logic [7:0] mode; int div; logic oe;} mrow_t;
    mrow_t rows [7] = '{'{8'h00, 1, 1'b1}, '{8'h01, 2, 1'b1}, '{8'h02, 8, 1'b1},
        '{8'h04, 1, 1'b1}, '{8'h05, 2, 1'b1}, '{8'h06, 8, 1'b1}, '{8'h03, 0, 1'b0}};
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic ci_change = 1'b0;
    logic sub_wake_n = 1'b1;
    logic wd_exp = 1'b0;
    logic dstrobe = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic osc_q, line_p, fs, highway_data_clock, highway_bit_clock, txt, mclk, moe, rout_n, last_b, last_fs;
    logic [7:0] rdata, r;
    logic [3:0] brst;
    int fail_count, comparisons, cycles, ivl, n_long, n_short, n_odd;
    int tk_frame, frame_ticks, clk_bad, n, nl, ns, bad;

    clock_gen_and_reset_dist #(.DEV_LIMIT(DEVN), .NUM_BLOCKS(4)) u_clock_gen_and_reset_dist (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .osc_quarter_i(osc_q),
        .line_pulse_i(line_p), .ci_change_i(ci_change), .subscriber_wake_in_n_i(sub_wake_n),
        .watchdog_expire_i(wd_exp), .data_strobe_i(dstrobe), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .frame_sync_o(fs), .highway_data_clock_o(highway_data_clock), .highway_bit_clock_o(highway_bit_clock),
        .line_tx_tick_o(txt), .mcu_clk_o(mclk), .mcu_clk_oe_o(moe),
        .reset_out_or_strobe_n_o(rout_n), .block_rst_o(brst));
    line_side_model #(.QGAP(QGAP)) u_line_side_model (
        .clk_sys_i(clk_sys_i), .frame_sync_i(fs), .osc_quarter_o(osc_q), .line_pulse_o(line_p));

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic chkn(input int got, input int lo, input int hi, input string msg);
        comparisons++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("mismatch at %0t: %s got %0d expected %0d..%0d", $time, msg, got, lo, hi);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata;
    endtask
    task automatic half_period(output int h);
        logic v;
        int k;
        k = 0;
        @(negedge clk_sys_i);
        v = mclk;
        while (mclk === v && k < 100) begin
            @(negedge clk_sys_i);
            k++;
        end
        v = mclk;
        h = 0;
        while (mclk === v && h < 100) begin
            @(negedge clk_sys_i);
            h++;
        end
    endtask
    // Pulse widths are counted in system clock cycles at the falling edge, not in quarter strobes.
    task automatic low_time(output int w);
        int k;
        k = 0;
        w = 0;
        while (rout_n !== 1'b0 && k < 8) begin
            @(negedge clk_sys_i);
            k++;
        end
        while (rout_n === 1'b0 && w < 3 * FRAME) begin
            @(negedge clk_sys_i);
            w++;
        end
    endtask
    task automatic fire(input int which);
        @(posedge clk_sys_i);
        ci_change <= (which == 0);
        sub_wake_n <= (which != 1);
        wd_exp <= (which == 2);
        @(posedge clk_sys_i);
        ci_change <= 1'b0;
        sub_wake_n <= 1'b1;
        wd_exp <= 1'b0;
    endtask

    always @(negedge clk_sys_i) begin
        cycles++;
        ivl++;
        if (txt === 1'b1) begin
            n_long += int'(ivl == DQ + MQ);
            n_short += int'(ivl == DQ - MQ);
            n_odd += int'(ivl != DQ && ivl != DQ + MQ && ivl != DQ - MQ);
            clk_bad += int'(highway_data_clock !== 1'b1 || highway_bit_clock === last_b);
            last_b = highway_bit_clock;
            ivl = 0;
            tk_frame++;
        end
        if (fs === 1'b1 && last_fs !== 1'b1) begin
            frame_ticks = tk_frame;
            tk_frame = 0;
        end
        last_fs = fs;
    end
    initial begin
        while (cycles < TIME_LIMIT) @(negedge clk_sys_i);
        fail_count++;
        $display("mismatch at %0t: run exceeded cycle limit", $time);
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk8(8'(rout_n), 8'h00, "reset out in reset");
        chk8(8'(brst), 8'h0F, "block resets in reset");
        chk8(8'({fs, highway_data_clock, highway_bit_clock, mclk, moe}), 8'h1D, "clock pins in reset");
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        bad = 0;
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
            bad += int'(rout_n !== 1'b0);
        end while (highway_bit_clock === 1'b1 && n < 400);
        repeat (3) @(negedge clk_sys_i);
        chkn(bad, 0, 0, "reset out held until bit clock falls");
        chkn(n, DQ, DQ + 3, "first bit clock fall");
        chk8(8'(rout_n), 8'h01, "reset out released");
        $display("test reset done");
        foreach (rows[i]) begin
            wr_reg(MODE, rows[i].mode);
            rd_reg(MODE, r);
            chk8(r, rows[i].mode, "mode readback");
            repeat (40) @(negedge clk_sys_i);
            chk8(8'(moe), 8'(rows[i].oe), "mcu clock enable");
            if (rows[i].oe) begin
                half_period(n);
                chkn(n, (MQ / 2 * rows[i].div) >> rows[i].mode[2], (MQ / 2 * rows[i].div) >>
                    rows[i].mode[2], "mcu half period");
            end else begin
                chk8(8'(mclk), 8'h00, "mcu clock stopped");
            end
        end
        $display("test mcu clock done");
        rd_reg(XCFG, r);
        chk8(r, clock_gen_pkg::LINE_XCVR_CONFIG_ONE_RST, "xcvr config reset value");
        wr_reg(4'hF, 8'hFF);
        rd_reg(4'hF, r);
        chk8(r, 8'h00, "unmapped read");
        chk8(8'(brst), 8'h00, "block resets idle");
        wr_reg(BRST, 8'h05);
        repeat (3) @(negedge clk_sys_i);
        chk8(8'(brst), 8'h05, "block reset held");
        rd_reg(BRST, r);
        chk8(r, 8'h05, "block reset readback");
        wr_reg(BRST, 8'h00);
        repeat (3) @(negedge clk_sys_i);
        chk8(8'(brst), 8'h00, "block reset released");
        $display("test registers done");
        clk_bad = 0;
        n_odd = 0;
        wr_reg(XCFG, 8'h01);
        nl = n_long;
        ns = n_short;
        u_line_side_model.send_marker(200);
        repeat (400) @(negedge clk_sys_i);
        chkn(n_long - nl, 1, 1, "late marker lengthens once");
        u_line_side_model.send_marker(6000);
        repeat (400) @(negedge clk_sys_i);
        chkn(n_short - ns, 1, 1, "early marker shortens once");
        wr_reg(XCFG, 8'h00);
        u_line_side_model.send_marker(1);
        for (int k = 1; k <= DEVN; k++) begin
            nl = n_long;
            u_line_side_model.send_marker(200);
            repeat (400) @(negedge clk_sys_i);
            chkn(n_long - nl, k / DEVN, k / DEVN, "integrated correction");
        end
        chkn(n_odd, 0, 0, "odd data clock period");
        chkn(frame_ticks, clock_gen_pkg::DCL_PER_FRAME, clock_gen_pkg::DCL_PER_FRAME,
            "data clocks per frame");
        chkn(clk_bad, 0, 0, "data and bit clock alignment");
        $display("test pll done");
        fire(0);
        low_time(n);
        chkn(n, 0, 0, "event ignored with no source");
        wr_reg(MODE, 8'h08);
        dstrobe <= 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk8(8'(rout_n), 8'h01, "strobe high passed");
        @(posedge clk_sys_i);
        dstrobe <= 1'b0;
        repeat (3) @(negedge clk_sys_i);
        chk8(8'(rout_n), 8'h00, "strobe low passed");
        wr_reg(MODE, 8'h10);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                wr_reg(MODE, 8'h18);
            end
            fire(k);
            low_time(n);
            chkn(n, FRAME, 2 * FRAME + 4, "internal reset pulse");
        end
        wr_reg(MODE, 8'h00);
        rd_reg(MODE, r);
        chk8(r, 8'h18, "select locked by watchdog");
        // A low clock enable must hold every output, the running controller clock included.
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        @(negedge clk_sys_i);
        r = {fs, highway_data_clock, highway_bit_clock, txt, mclk, moe, rout_n, brst[0]};
        repeat (50) @(negedge clk_sys_i);
        chk8({fs, highway_data_clock, highway_bit_clock, txt, mclk, moe, rout_n, brst[0]}, r, "frozen by enable");
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd_reg(MODE, r);
        chk8(r, clock_gen_pkg::PRIMARY_MODE_CONFIG_RST, "mode after reset");
        chk8(8'(rout_n), 8'h00, "reset out held after second reset");
        rd_reg(clock_gen_pkg::CLOCK_STATUS_ADDR, r);
        chk8(r, 8'h04, "status shows hardware reset hold");
        $display("test reset out done");
        give_verdict();
    end
endmodule
